// *** rtl/mrb_addr_unit.sv ***
// Operand address generation, memory-mapped register checks and
// register-bit addressing, with an AHB-Lite register slave.
// Assumes core request inputs are on clk and held for one cycle.
// What this block does
// - Pre-modify: add offset, then form address
// - Long partner address: even plus one, odd minus
// - Offset operand never issued in parallel; one issued in parallel still completes and only sets a status bit
// - Byte access to mapped register raises bus error
// - Dual, coefficient or stack mapped access: bus error
// - Second buses and coefficient bus blocked for registers
// - Faulting instruction results not guaranteed
// - Bit addressing: direct or indirect, never absolute
// - No I/O qualifier with bit operands
// - Direct offset is the bit address
// - Pair test copies two bits to flags
// - Bit ops only on accumulator, aux, temp
// - Mode zero accepts all pointer bit forms except short offset
// - Mode one: restricted forms plus short offset
// - Coefficient pointer bit forms accepted
// - Bit pointer steps one or two
//
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module mrb_addr_unit #(
	parameter logic [15:0] MMR_TOP = 16'h0060
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Word access request
	input wire logic acc_req,
	input wire mrb_pkg::mrb_kind_e acc_kind,
	input wire mrb_pkg::mrb_cmode_e acc_mode,
	input wire logic parallel_issue,
	input wire logic [15:0] coef_pointer,
	input wire logic [6:0] coef_pointer_high,
	input wire logic [15:0] coef_circ_base,
	input wire logic [15:0] signed_offset_const,
	// Word access answer
	output logic acc_done,
	output logic [22:0] full_coef_address,
	output logic [22:0] second_address,
	output logic [15:0] coef_pointer_next,
	output logic addr_blocked,
	output logic bus_error_irq,
	// Bit request
	input wire logic bit_req,
	input wire mrb_pkg::mrb_bop_e bit_op,
	input wire mrb_pkg::mrb_bform_e bit_form,
	input wire logic io_qualifier,
	input wire mrb_pkg::mrb_rcls_e target_cls,
	input wire logic [15:0] bit_pointer,
	input wire logic [15:0] bit_index,
	input wire logic [15:0] bit_offset,
	input wire logic [15:0] aux_circ_base,
	input wire logic bit_circ,
	input wire logic [39:0] src_value,
	// Bit answer
	output logic bit_done,
	output logic bit_reject,
	output logic [39:0] bit_result,
	output logic [15:0] bit_pointer_next,
	output logic [15:0] bit_addr_out,
	output logic test_flag_one,
	output logic test_flag_two,
	// Interrupt
	output logic irq
);
	function automatic logic [15:0] rev16(input logic [15:0] v);
		logic [15:0] r;
		for (int i = 0; i < 16; i++) begin
			r[i] = v[15 - i];
		end
		return r;
	endfunction : rev16

	logic [1:0] ctrl_reg, ctrl_next;
	logic [2:0] mask_reg, mask_next;
	logic [2:0] status_reg, status_next;
	logic [22:0] fault_reg, fault_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic dp_wr_reg, dp_wr_next;
	logic [11:0] dp_addr_reg, dp_addr_next;
	logic ap_take, rd_clr;
	logic berr_ev, brej_ev, prej_ev;
	logic circ_on, aux_reg_mode_select;

	assign circ_on = ctrl_reg[mrb_pkg::CTRL_CIRC_POS];
	assign aux_reg_mode_select = ctrl_reg[mrb_pkg::CTRL_AUX_REG_MODE_SELECT_POS];

	// Word access group
	logic [15:0] cstep, cptr_new, cptr_eff, cptr_base;
	logic [22:0] addr_first, addr_pair;
	logic is_mmr, k16_mode, blk_bus, berr_hit;
	logic acc_done_reg, blocked_reg, berr_reg;
	logic [22:0] fca_reg, sec_reg;
	logic [15:0] cpn_reg;

	mrb_pair_addr #(.W(23)) u_pair (
		.first_addr(addr_first),
		.second_addr(addr_pair)
	);

	always_comb begin
		cstep = (acc_kind == mrb_pkg::K_LONG) ? mrb_pkg::STEP_TWO
			: mrb_pkg::STEP_ONE;
		case (acc_mode)
		mrb_pkg::CM_PINC: cptr_new = coef_pointer + cstep;
		mrb_pkg::CM_PDEC: cptr_new = coef_pointer - cstep;
		mrb_pkg::CM_PRE_K16: cptr_new = coef_pointer + signed_offset_const;
		default: cptr_new = coef_pointer;
		endcase
		cptr_eff = (acc_mode == mrb_pkg::CM_PRE_K16) ? cptr_new
			: coef_pointer;
		cptr_base = circ_on ? coef_circ_base + cptr_eff : cptr_eff;
		if (acc_mode == mrb_pkg::CM_K16) begin
			cptr_base = cptr_base + signed_offset_const;
		end
		addr_first = {coef_pointer_high, cptr_base};
		is_mmr = (addr_first[22:16] == 7'h00) && (addr_first[15:0] < MMR_TOP);
		k16_mode = (acc_mode == mrb_pkg::CM_K16)
			|| (acc_mode == mrb_pkg::CM_PRE_K16);
		// Buses with no path to the register file
		blk_bus = (acc_kind == mrb_pkg::K_DWR_X)
			|| (acc_kind == mrb_pkg::K_DRD_Y)
			|| (acc_kind == mrb_pkg::K_COEF);
		berr_hit = is_mmr && (blk_bus || acc_kind == mrb_pkg::K_BYTE
			|| acc_kind == mrb_pkg::K_STACK);
		berr_ev = acc_req && berr_hit;
		prej_ev = acc_req && k16_mode && parallel_issue;
	end

	// Faulting access still completes; its results are not trusted
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			acc_done_reg <= 1'b0;
			blocked_reg <= 1'b0;
			berr_reg <= 1'b0;
			fca_reg <= 23'h000000;
			sec_reg <= 23'h000000;
			cpn_reg <= 16'h0000;
		end else begin
			acc_done_reg <= acc_req;
			blocked_reg <= acc_req && is_mmr && blk_bus;
			berr_reg <= berr_ev;
			fca_reg <= acc_req ? addr_first : fca_reg;
			sec_reg <= acc_req ? addr_pair : sec_reg;
			cpn_reg <= acc_req ? cptr_new : cpn_reg;
		end
	end

	assign acc_done = acc_done_reg;
	assign full_coef_address = fca_reg;
	assign second_address = sec_reg;
	assign coef_pointer_next = cpn_reg;
	assign addr_blocked = blocked_reg;
	assign bus_error_irq = berr_reg;

	// Bit group
	logic pair, bpre, form_ok, range_ok, bit_ok;
	logic [15:0] bstep, bptr_new, bptr_eff, boff, baddr;
	logic [6:0] wlim, top_bit;
	logic [39:0] bres;
	logic blo, bhi;
	logic bdone_reg, brej_reg, tf1_reg, tf2_reg;
	logic [39:0] bres_reg, src_q;
	logic [15:0] bpn_reg, baddr_reg;

	mrb_bit_op #(.W(40), .IW(6)) u_bit (
		.value(src_value),
		.index(baddr[5:0]),
		.op(bit_op),
		.result(bres),
		.bit_lo(blo),
		.bit_hi(bhi)
	);

	always_comb begin
		pair = (bit_op == mrb_pkg::BO_PAIR);
		bstep = pair ? mrb_pkg::STEP_TWO : mrb_pkg::STEP_ONE;
		bptr_new = bit_pointer;
		bpre = 1'b0;
		boff = 16'h0000;
		case (bit_form)
		mrb_pkg::BF_AR_PINC, mrb_pkg::BF_CDP_PINC:
			bptr_new = bit_pointer + bstep;
		mrb_pkg::BF_AR_PDEC, mrb_pkg::BF_CDP_PDEC:
			bptr_new = bit_pointer - bstep;
		mrb_pkg::BF_AR_PREINC: begin
			bptr_new = bit_pointer + bstep;
			bpre = 1'b1;
		end
		mrb_pkg::BF_AR_PREDEC: begin
			bptr_new = bit_pointer - bstep;
			bpre = 1'b1;
		end
		mrb_pkg::BF_AR_ADD_T0, mrb_pkg::BF_AR_ADD_T1:
			bptr_new = bit_pointer + bit_index;
		mrb_pkg::BF_AR_SUB_T0, mrb_pkg::BF_AR_SUB_T1:
			bptr_new = bit_pointer - bit_index;
		mrb_pkg::BF_AR_IDX_T0, mrb_pkg::BF_AR_IDX_T1:
			boff = bit_index;
		// Reverse-carry add for bit-reversed stepping
		mrb_pkg::BF_AR_ADD_T0B:
			bptr_new = rev16(rev16(bit_pointer) + rev16(bit_index));
		mrb_pkg::BF_AR_SUB_T0B:
			bptr_new = rev16(rev16(bit_pointer)
				+ rev16(16'h0000 - bit_index));
		mrb_pkg::BF_AR_K16, mrb_pkg::BF_CDP_K16:
			boff = bit_offset;
		mrb_pkg::BF_AR_PRE_K16, mrb_pkg::BF_CDP_PRE_K16: begin
			bptr_new = bit_pointer + bit_offset;
			bpre = 1'b1;
		end
		mrb_pkg::BF_AR_K3:
			boff = {13'h0000, bit_offset[2:0]};
		default:
			bptr_new = bit_pointer;
		endcase
		bptr_eff = bpre ? bptr_new : bit_pointer;
		baddr = (bit_circ ? aux_circ_base + bptr_eff : bptr_eff)
			+ boff;
		if (bit_form == mrb_pkg::BF_DIRECT) begin
			baddr = bit_offset;
		end
		case (bit_form)
		mrb_pkg::BF_AR_K3:
			form_ok = aux_reg_mode_select;
		mrb_pkg::BF_AR_PREINC, mrb_pkg::BF_AR_PREDEC,
		mrb_pkg::BF_AR_ADD_T0B, mrb_pkg::BF_AR_SUB_T0B,
		mrb_pkg::BF_AR_ADD_T1, mrb_pkg::BF_AR_SUB_T1,
		mrb_pkg::BF_AR_IDX_T1:
			form_ok = !aux_reg_mode_select;
		mrb_pkg::BF_ABS:
			form_ok = 1'b0;
		default:
			form_ok = 1'b1;
		endcase
		wlim = (target_cls == mrb_pkg::RC_ACC) ? mrb_pkg::ACC_BITS
			: mrb_pkg::WORD_BITS;
		top_bit = {1'b0, baddr[5:0]} + (pair ? 7'h01 : 7'h00);
		range_ok = (baddr[15:6] == 10'h000) && (top_bit < wlim);
		// Pointer must already hold the bit number
		bit_ok = form_ok && !io_qualifier
			&& (target_cls != mrb_pkg::RC_OTHER)
			&& range_ok
			&& (bit_op inside {mrb_pkg::BO_TEST, mrb_pkg::BO_SET,
			mrb_pkg::BO_CLR, mrb_pkg::BO_CPL, mrb_pkg::BO_PAIR});
		brej_ev = bit_req && !bit_ok;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bdone_reg <= 1'b0;
			brej_reg <= 1'b0;
			tf1_reg <= 1'b0;
			tf2_reg <= 1'b0;
			bres_reg <= 40'h0000000000;
			src_q <= 40'h0000000000;
			bpn_reg <= 16'h0000;
			baddr_reg <= 16'h0000;
		end else begin
			bdone_reg <= bit_req && bit_ok;
			brej_reg <= brej_ev;
			if (bit_req && bit_ok) begin
				bres_reg <= bres;
				src_q <= src_value;
				bpn_reg <= bptr_new;
				baddr_reg <= baddr;
				if (bit_op == mrb_pkg::BO_TEST || pair) begin
					tf1_reg <= blo;
				end
				if (pair) begin
					tf2_reg <= bhi;
				end
			end
		end
	end

	assign bit_done = bdone_reg;
	assign bit_reject = brej_reg;
	assign bit_result = bres_reg;
	assign bit_pointer_next = bpn_reg;
	assign bit_addr_out = baddr_reg;
	assign test_flag_one = tf1_reg;
	assign test_flag_two = tf2_reg;

	// Register slave group, zero wait states
	assign ap_take = hsel && htrans[1] && hready;

	always_comb begin
		dp_wr_next = ap_take && hwrite;
		dp_addr_next = ap_take ? haddr[11:0] : dp_addr_reg;
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		if (dp_wr_reg && dp_addr_reg == mrb_pkg::OFF_CTRL) begin
			ctrl_next = hwdata[1:0];
		end
		if (dp_wr_reg && dp_addr_reg == mrb_pkg::OFF_MASK) begin
			mask_next = hwdata[2:0];
		end
		rd_clr = ap_take && !hwrite && haddr[11:0] == mrb_pkg::OFF_STATUS;
		// New event wins over the read that clears
		status_next = (rd_clr ? mrb_pkg::STATUS_RST : status_reg)
			| {prej_ev, brej_ev, berr_ev};
		fault_next = berr_ev ? addr_first : fault_reg;
		hrdata_next = hrdata_reg;
		// Reads see a write still in its data phase
		if (ap_take && !hwrite) begin
			case (haddr[11:0])
			mrb_pkg::OFF_CTRL: hrdata_next = {30'h00000000, ctrl_next};
			mrb_pkg::OFF_STATUS: hrdata_next = {29'h00000000, status_reg};
			mrb_pkg::OFF_MASK: hrdata_next = {29'h00000000, mask_next};
			mrb_pkg::OFF_FAULT: hrdata_next = {9'h000, fault_reg};
			default: hrdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= mrb_pkg::CTRL_RST;
			mask_reg <= mrb_pkg::MASK_RST;
			status_reg <= mrb_pkg::STATUS_RST;
			fault_reg <= mrb_pkg::FAULT_RST;
			hrdata_reg <= 32'h00000000;
			dp_wr_reg <= 1'b0;
			dp_addr_reg <= 12'h000;
		end else begin
			ctrl_reg <= ctrl_next;
			mask_reg <= mask_next;
			status_reg <= status_next;
			fault_reg <= fault_next;
			hrdata_reg <= hrdata_next;
			dp_wr_reg <= dp_wr_next;
			dp_addr_reg <= dp_addr_next;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign irq = |(status_reg & mask_reg);

	// Checks
	a_pre_k16_addr: assert property (@(posedge clk) disable iff (!nrst)
		acc_req && acc_mode == mrb_pkg::CM_PRE_K16 && !circ_on |=>
		fca_reg[15:0] == $past(coef_pointer) + $past(signed_offset_const)
		&& cpn_reg == fca_reg[15:0])
		else $error("pre-modify address wrong");
	a_long_pair: assert property (@(posedge clk) disable iff (!nrst)
		acc_done |-> second_address == (full_coef_address ^ 23'h000001))
		else $error("long partner address wrong");
	a_par_offset: assert property (@(posedge clk) disable iff (!nrst)
		acc_req && parallel_issue && acc_mode == mrb_pkg::CM_K16 |=>
		status_reg[mrb_pkg::ST_PREJ_POS])
		else $error("parallel offset operand not flagged");
	a_byte_mmr: assert property (@(posedge clk) disable iff (!nrst)
		acc_req && acc_kind == mrb_pkg::K_BYTE && is_mmr |=>
		bus_error_irq && status_reg[mrb_pkg::ST_BERR_POS])
		else $error("byte access to register not faulted");
	a_bus_block: assert property (@(posedge clk) disable iff (!nrst)
		acc_req && blk_bus && is_mmr |=> addr_blocked && bus_error_irq
		##1 !bus_error_irq || $past(berr_ev))
		else $error("blocked bus reached a register");
	a_stack_mmr: assert property (@(posedge clk) disable iff (!nrst)
		acc_req && acc_kind == mrb_pkg::K_STACK && is_mmr |=>
		bus_error_irq && !addr_blocked)
		else $error("stack access to register not faulted");
	a_abs_io_rej: assert property (@(posedge clk) disable iff (!nrst)
		bit_req && (bit_form == mrb_pkg::BF_ABS || io_qualifier) |=>
		bit_reject && !bit_done)
		else $error("absolute or I/O bit operand accepted");
	a_direct_set: assert property (@(posedge clk) disable iff (!nrst)
		(bit_req && bit_form == mrb_pkg::BF_DIRECT
		&& bit_op == mrb_pkg::BO_SET) ##1 bit_done |->
		bit_result == (src_q | (40'h0000000001 << bit_addr_out[5:0]))
		&& bit_addr_out == $past(bit_offset))
		else $error("direct bit set wrong");
	a_pair_flags: assert property (@(posedge clk) disable iff (!nrst)
		(bit_req && bit_op == mrb_pkg::BO_PAIR) ##1 bit_done |->
		test_flag_one == src_q[bit_addr_out[5:0]]
		&& test_flag_two == src_q[bit_addr_out[5:0] + 6'h01])
		else $error("pair test flags wrong");
	a_target_cls: assert property (@(posedge clk) disable iff (!nrst)
		bit_req && target_cls == mrb_pkg::RC_OTHER |=> bit_reject)
		else $error("bit op on other register accepted");
	a_mode_forms: assert property (@(posedge clk) disable iff (!nrst)
		bit_req && ((aux_reg_mode_select && bit_form == mrb_pkg::BF_AR_PREINC)
		|| (!aux_reg_mode_select && bit_form == mrb_pkg::BF_AR_K3)) |=> bit_reject)
		else $error("bit form illegal in this mode");
	a_pair_step: assert property (@(posedge clk) disable iff (!nrst)
		(bit_req && bit_form inside {mrb_pkg::BF_AR_PINC,
		mrb_pkg::BF_CDP_PINC} && bit_op == mrb_pkg::BO_PAIR)
		##1 bit_done |->
		bit_pointer_next == $past(bit_pointer) + 16'h0002)
		else $error("pair step not two");
endmodule : mrb_addr_unit

// *** rtl/mrb_bit_op.sv ***
// Single-bit and bit-pair operation on one register value.
// Combinational; index range is checked by the caller.
`timescale 1ns/1ps
module mrb_bit_op #(
	parameter int W = 40,
	parameter int IW = 6
) (
	// Operand
	input wire logic [W-1:0] value,
	input wire logic [IW-1:0] index,
	input wire mrb_pkg::mrb_bop_e op,
	// Results
	output logic [W-1:0] result,
	output logic bit_lo,
	output logic bit_hi
);
	logic [W-1:0] sel;
	logic [W-1:0] sh;

	assign sel = {{(W-1){1'b0}}, 1'b1} << index;
	// Shift keeps the upper read in range at the top bit
	assign sh = value >> index;
	assign bit_lo = sh[0];
	assign bit_hi = sh[1];

	always_comb begin
		case (op)
		mrb_pkg::BO_SET: result = value | sel;
		mrb_pkg::BO_CLR: result = value & ~sel;
		mrb_pkg::BO_CPL: result = value ^ sel;
		default: result = value;
		endcase
	end
endmodule : mrb_bit_op

// *** rtl/mrb_pair_addr.sv ***
// Second word address of a long-word access.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module mrb_pair_addr #(
	parameter int W = 23
) (
	// First word address
	input wire logic [W-1:0] first_addr,
	// Partner word address
	output logic [W-1:0] second_addr
);
	// Even goes up, odd goes down: the pair never straddles alignment
	assign second_addr = first_addr[0] ? first_addr - W'(1)
		: first_addr + W'(1);
endmodule : mrb_pair_addr

// *** rtl/mrb_pkg.sv ***
// Constants and types for the operand address and register-bit unit.
// Used by every design file except mrb_pair_addr; assumes nothing of its surroundings.
package mrb_pkg;
	// Register byte offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_MASK = 12'h008;
	localparam logic [11:0] OFF_FAULT = 12'h00C;
	// Field positions
	localparam int CTRL_CIRC_POS = 0;
	localparam int CTRL_AUX_REG_MODE_SELECT_POS = 1;
	localparam int ST_BERR_POS = 0;
	localparam int ST_BREJ_POS = 1;
	localparam int ST_PREJ_POS = 2;
	// Values after reset
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [2:0] MASK_RST = 3'h0;
	localparam logic [2:0] STATUS_RST = 3'h0;
	localparam logic [22:0] FAULT_RST = 23'h000000;
	// Pointer steps
	localparam logic [15:0] STEP_ONE = 16'h0001;
	localparam logic [15:0] STEP_TWO = 16'h0002;
	// Register widths for bit range checks
	localparam logic [6:0] ACC_BITS = 7'h28;
	localparam logic [6:0] WORD_BITS = 7'h10;

	typedef enum logic [2:0] {
		K_WORD = 3'b000, K_LONG = 3'b001, K_BYTE = 3'b010,
		K_DWR_X = 3'b011, K_DRD_Y = 3'b100, K_COEF = 3'b101,
		K_STACK = 3'b110
	} mrb_kind_e;

	typedef enum logic [2:0] {
		CM_PLAIN = 3'b000, CM_PINC = 3'b001, CM_PDEC = 3'b010,
		CM_K16 = 3'b011, CM_PRE_K16 = 3'b100
	} mrb_cmode_e;

	typedef enum logic [4:0] {
		BF_DIRECT = 5'h00, BF_AR = 5'h01, BF_AR_PINC = 5'h02,
		BF_AR_PDEC = 5'h03, BF_AR_PREINC = 5'h04, BF_AR_PREDEC = 5'h05,
		BF_AR_ADD_T0 = 5'h06, BF_AR_SUB_T0 = 5'h07, BF_AR_IDX_T0 = 5'h08,
		BF_AR_ADD_T0B = 5'h09, BF_AR_SUB_T0B = 5'h0A,
		BF_AR_ADD_T1 = 5'h0B, BF_AR_SUB_T1 = 5'h0C, BF_AR_IDX_T1 = 5'h0D,
		BF_AR_K16 = 5'h0E, BF_AR_PRE_K16 = 5'h0F, BF_AR_K3 = 5'h10,
		BF_CDP = 5'h11, BF_CDP_PINC = 5'h12, BF_CDP_PDEC = 5'h13,
		BF_CDP_K16 = 5'h14, BF_CDP_PRE_K16 = 5'h15, BF_ABS = 5'h16
	} mrb_bform_e;

	typedef enum logic [2:0] {
		BO_TEST = 3'b000, BO_SET = 3'b001, BO_CLR = 3'b010,
		BO_CPL = 3'b011, BO_PAIR = 3'b100
	} mrb_bop_e;

	typedef enum logic [1:0] {
		RC_ACC = 2'b00, RC_AUX = 2'b01, RC_TEMP = 2'b10, RC_OTHER = 2'b11
	} mrb_rcls_e;
endpackage : mrb_pkg

// *** sim/mrb_addr_unit_test.sv ***
// Self-checking bench for the operand address and register-bit unit.
// Assumes mrb_core_model drives the bit request side.
`timescale 1ns/1ps
module mrb_addr_unit_test;
	logic clk, nrst, hsel, hwrite, hready, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic acc_req, parallel_issue, acc_done, addr_blocked, bus_error_irq;
	mrb_pkg::mrb_kind_e acc_kind;
	mrb_pkg::mrb_cmode_e acc_mode;
	logic [15:0] coef_pointer, coef_circ_base, signed_offset_const;
	logic [15:0] coef_pointer_next, bit_pointer, bit_index, bit_offset;
	logic [15:0] aux_circ_base, bit_pointer_next, bit_addr_out;
	logic [6:0] coef_pointer_high;
	logic [22:0] full_coef_address, second_address;
	logic bit_req, io_qualifier, bit_circ, bit_done, bit_reject, ok, rj;
	logic test_flag_one, test_flag_two;
	mrb_pkg::mrb_bop_e bit_op;
	mrb_pkg::mrb_bform_e bit_form;
	mrb_pkg::mrb_rcls_e target_cls;
	logic [39:0] src_value, bit_result;
	int fails, check_count;
	assign hready = hreadyout;
	always #20 clk = ~clk;
	mrb_addr_unit mrb_addr_unit_i (.clk, .nrst, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hready, .hwdata, .hreadyout, .hresp,
		.hrdata, .acc_req, .acc_kind, .acc_mode, .parallel_issue,
		.coef_pointer, .coef_pointer_high, .coef_circ_base,
		.signed_offset_const, .acc_done, .full_coef_address,
		.second_address, .coef_pointer_next, .addr_blocked,
		.bus_error_irq, .bit_req, .bit_op, .bit_form, .io_qualifier,
		.target_cls, .bit_pointer, .bit_index, .bit_offset,
		.aux_circ_base, .bit_circ, .src_value, .bit_done, .bit_reject,
		.bit_result, .bit_pointer_next, .bit_addr_out, .test_flag_one,
		.test_flag_two, .irq);
	mrb_core_model mrb_core_model_i (.clk, .bit_req, .bit_op, .bit_form,
		.io_qualifier, .target_cls, .bit_pointer, .bit_index, .bit_offset,
		.aux_circ_base, .bit_circ, .src_value, .bit_done, .bit_reject,
		.bit_result, .bit_pointer_next);
	task automatic complete_run;
		if (fails == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string what, input logic [63:0] exp,
		input logic [63:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic hang_check(input int n);
		if (n >= 8) begin
			fails++;
			complete_run();
		end
	endtask : hang_check
	task automatic wait_ready;
		int n;
		for (n = 0; n < 8; n++) begin
			@(posedge clk);
			if (hready === 1'b1) break;
		end
		hang_check(n);
	endtask : wait_ready
	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [31:0] wd);
		@(posedge clk);
		{hsel, htrans, hwrite} <= {1'b1, 2'h2, wr};
		haddr <= {20'h00000, a};
		wait_ready();
		{hsel, htrans} <= 3'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask : bus
	task automatic reg_chk(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk($sformatf("register %h", a), exp, rd);
		chk("response", 1'b0, hresp);
	endtask : reg_chk
	task automatic acc(input mrb_pkg::mrb_kind_e k,
		input mrb_pkg::mrb_cmode_e m, input logic par,
		input logic [15:0] p, input logic [6:0] hi, input logic [15:0] kc);
		int n;
		@(posedge clk);
		{acc_req, parallel_issue} <= {1'b1, par};
		acc_kind <= k;
		acc_mode <= m;
		{coef_pointer, coef_pointer_high} <= {p, hi};
		signed_offset_const <= kc;
		@(posedge clk);
		{acc_req, parallel_issue} <= 2'b00;
		{coef_pointer, signed_offset_const} <= {~p, ~kc};
		for (n = 0; n < 8; n++) begin
			#1;
			if (acc_done === 1'b1) break;
			@(posedge clk);
		end
		hang_check(n);
	endtask : acc
	task automatic bop(input mrb_pkg::mrb_bop_e op,
		input mrb_pkg::mrb_bform_e f, input mrb_pkg::mrb_rcls_e c,
		input logic io, input logic [15:0] off, input logic exp_ok);
		mrb_core_model_i.issue(op, f, c, io, 16'h0001, off, ok, rj);
		chk("accept and refuse", {exp_ok, !exp_ok}, {ok, rj});
		if (ok !== 1'b1 && rj !== 1'b1) hang_check(8);
	endtask : bop
	task automatic t_regs;
		for (int a = 0; a < 20; a += 4) reg_chk(a[11:0], 32'h0);
		bus(1'b1, 12'h010, 32'h3);
		reg_chk(12'h010, 32'h0);
		bus(1'b1, mrb_pkg::OFF_CTRL, 32'h3);
		reg_chk(mrb_pkg::OFF_CTRL, 32'h3);
		bus(1'b1, mrb_pkg::OFF_CTRL, 32'h0);
	endtask : t_regs
	task automatic t_coef;
		acc(mrb_pkg::K_WORD, mrb_pkg::CM_PRE_K16, 0, 16'h0010, 7'h01, 16'h0028);
		chk("coef", 39'h0100380038, {full_coef_address, coef_pointer_next});
		acc(mrb_pkg::K_LONG, mrb_pkg::CM_PRE_K16, 0, 16'h0100, 7'h01, 16'hFFF0);
		chk("pair", {23'h0100F0, 23'h0100F1},
			{full_coef_address, second_address});
		acc(mrb_pkg::K_LONG, mrb_pkg::CM_K16, 0, 16'h0100, 7'h01, 16'h0009);
		chk("second", 23'h010108, second_address);
		bus(1'b1, mrb_pkg::OFF_CTRL, 32'h1);
		acc(mrb_pkg::K_WORD, mrb_pkg::CM_PRE_K16, 0, 16'h0010, 7'h01, 16'h0028);
		chk("circ", 39'h0101380038, {full_coef_address, coef_pointer_next});
		bus(1'b1, mrb_pkg::OFF_CTRL, 32'h0);
		acc(mrb_pkg::K_WORD, mrb_pkg::CM_K16, 1, 16'h0100, 7'h01, 16'h0004);
		reg_chk(mrb_pkg::OFF_STATUS, 32'h4);
		reg_chk(mrb_pkg::OFF_STATUS, 32'h0);
	endtask : t_coef
	task automatic t_mmr;
		logic be, bl;
		bus(1'b1, mrb_pkg::OFF_MASK, 32'h1);
		for (int i = 0; i < 7; i++) begin
			{be, bl} = {i >= 2, i >= 3 && i <= 5};
			acc(mrb_pkg::mrb_kind_e'(i[2:0]), mrb_pkg::CM_PLAIN, 0, 16'h0010,
				7'h00, 16'h0000);
			chk("error and block", {be, bl}, {bus_error_irq, addr_blocked});
			@(posedge clk);
			#1;
			chk("irq raised", be, irq);
			reg_chk(mrb_pkg::OFF_STATUS, {31'h0, be});
			@(posedge clk);
			#1;
			chk("irq cleared", 1'b0, irq);
		end
		// Data of a faulting access is left unchecked
		reg_chk(mrb_pkg::OFF_FAULT, 32'h10);
		bus(1'b1, mrb_pkg::OFF_MASK, 32'h0);
		acc(mrb_pkg::K_STACK, mrb_pkg::CM_PLAIN, 0, 16'h0020, 7'h00, 16'h0);
		@(posedge clk);
		#1;
		chk("irq masked", 1'b0, irq);
		reg_chk(mrb_pkg::OFF_STATUS, 32'h1);
	endtask : t_mmr
	task automatic t_bits;
		mrb_core_model_i.load(16'h0000, 40'h0);
		bop(mrb_pkg::BO_SET, mrb_pkg::BF_DIRECT, mrb_pkg::RC_ACC, 0, 5, 1);
		chk("set", {16'h5, 40'h20}, {bit_addr_out, bit_result});
		bop(mrb_pkg::BO_SET, mrb_pkg::BF_DIRECT, mrb_pkg::RC_ACC, 0, 39, 1);
		chk("set top", 40'h8000000020, bit_result);
		bop(mrb_pkg::BO_CLR, mrb_pkg::BF_DIRECT, mrb_pkg::RC_ACC, 0, 39, 1);
		chk("clear", 40'h20, bit_result);
		bop(mrb_pkg::BO_CPL, mrb_pkg::BF_DIRECT, mrb_pkg::RC_ACC, 0, 5, 1);
		chk("complement", 40'h0, bit_result);
		mrb_core_model_i.load(16'h0000, 40'h0080000000);
		bop(mrb_pkg::BO_PAIR, mrb_pkg::BF_DIRECT, mrb_pkg::RC_ACC, 0, 30, 1);
		chk("pair flags", 2'b01, {test_flag_one, test_flag_two});
		bop(mrb_pkg::BO_TEST, mrb_pkg::BF_DIRECT, mrb_pkg::RC_ACC, 0, 31, 1);
		chk("test flags", 2'b11, {test_flag_one, test_flag_two});
		bop(mrb_pkg::BO_PAIR, mrb_pkg::BF_DIRECT, mrb_pkg::RC_ACC, 0, 39, 0);
		bop(mrb_pkg::BO_SET, mrb_pkg::BF_DIRECT, mrb_pkg::RC_AUX, 0, 15, 1);
		bop(mrb_pkg::BO_SET, mrb_pkg::BF_DIRECT, mrb_pkg::RC_TEMP, 0, 16, 0);
		bop(mrb_pkg::BO_SET, mrb_pkg::BF_DIRECT, mrb_pkg::RC_OTHER, 0, 5, 0);
		bop(mrb_pkg::BO_SET, mrb_pkg::BF_DIRECT, mrb_pkg::RC_ACC, 1, 5, 0);
		bop(mrb_pkg::BO_SET, mrb_pkg::BF_ABS, mrb_pkg::RC_ACC, 0, 5, 0);
		reg_chk(mrb_pkg::OFF_STATUS, 32'h2);
	endtask : t_bits
	task automatic t_forms;
		logic [16:0] ok_set;
		for (int m = 0; m < 2; m++) begin
			bus(1'b1, mrb_pkg::OFF_CTRL, {30'h0, m[0], 1'b0});
			ok_set = m ? 17'h1C1CE : 17'h0FFFE;
			for (int f = 1; f < 17; f++) begin
				mrb_core_model_i.load(16'h0004, 40'h0);
				bop(mrb_pkg::BO_SET, mrb_pkg::mrb_bform_e'(f[4:0]),
					mrb_pkg::RC_ACC, 0, 1, ok_set[f]);
			end
		end
		mrb_core_model_i.load(16'h0004, 40'h0);
		bop(mrb_pkg::BO_PAIR, mrb_pkg::BF_AR_PINC, mrb_pkg::RC_ACC, 0, 0, 1);
		chk("pair step", {16'h4, 16'h6}, {bit_addr_out, bit_pointer_next});
		bus(1'b1, mrb_pkg::OFF_CTRL, 32'h0);
		mrb_core_model_i.load(16'h0003, 40'h0);
		bop(mrb_pkg::BO_SET, mrb_pkg::BF_AR_PREINC, mrb_pkg::RC_ACC, 0, 0, 1);
		chk("pre step", {16'h4, 16'h4}, {bit_addr_out, bit_pointer_next});
		for (int f = 17; f < 22; f++) begin
			mrb_core_model_i.load(16'h0004, 40'h0);
			bop(mrb_pkg::BO_SET, mrb_pkg::mrb_bform_e'(f[4:0]),
				mrb_pkg::RC_ACC, 0, 1, 1);
		end
		chk("coef pre offset", 16'h5, bit_pointer_next);
		// Circular base on an aux pointer bit operand
		mrb_core_model_i.circ_on = 1'b1;
		mrb_core_model_i.load(16'h0002, 40'h0);
		bop(mrb_pkg::BO_SET, mrb_pkg::BF_AR, mrb_pkg::RC_ACC, 0, 0, 1);
		chk("circ bit address", 16'h12, bit_addr_out);
	endtask : t_forms
	initial begin
		{clk, nrst, hsel, hwrite, acc_req, parallel_issue} = '0;
		{haddr, hwdata, htrans, coef_pointer, signed_offset_const} = '0;
		{coef_pointer_high, coef_circ_base} = {7'h00, 16'h0100};
		acc_kind = mrb_pkg::K_WORD;
		acc_mode = mrb_pkg::CM_PLAIN;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_coef();
		t_mmr();
		t_bits();
		t_forms();
		complete_run();
	end
endmodule : mrb_addr_unit_test

// *** sim/mrb_core_model.sv ***
// Core-side model: pointer and operand registers, bit request issue.
// Assumes the unit answers a bit request within a few clock cycles.
`timescale 1ns/1ps
module mrb_core_model (
	// Clock
	input wire logic clk,
	// Bit request
	output logic bit_req,
	output mrb_pkg::mrb_bop_e bit_op,
	output mrb_pkg::mrb_bform_e bit_form,
	output logic io_qualifier,
	output mrb_pkg::mrb_rcls_e target_cls,
	output logic [15:0] bit_pointer,
	output logic [15:0] bit_index,
	output logic [15:0] bit_offset,
	output logic [15:0] aux_circ_base,
	output logic bit_circ,
	output logic [39:0] src_value,
	// Bit answer
	input wire logic bit_done,
	input wire logic bit_reject,
	input wire logic [39:0] bit_result,
	input wire logic [15:0] bit_pointer_next
);
	logic [15:0] ptr_reg;
	logic [39:0] val_reg;
	logic circ_on;
	initial begin
		{bit_req, io_qualifier, bit_circ, circ_on} = '0;
		{bit_pointer, bit_index, bit_offset, ptr_reg} = '0;
		{src_value, val_reg} = '0;
		aux_circ_base = 16'h0010;
		bit_op = mrb_pkg::BO_TEST;
		bit_form = mrb_pkg::BF_DIRECT;
		target_cls = mrb_pkg::RC_ACC;
	end
	task automatic load(input logic [15:0] p, input logic [39:0] v);
		ptr_reg = p;
		val_reg = v;
	endtask : load
	task automatic issue(input mrb_pkg::mrb_bop_e op,
		input mrb_pkg::mrb_bform_e f, input mrb_pkg::mrb_rcls_e c,
		input logic io, input logic [15:0] idx, input logic [15:0] off,
		output logic ok, output logic rj);
		int n;
		@(posedge clk);
		bit_req <= 1'b1;
		bit_op <= op;
		bit_form <= f;
		target_cls <= c;
		{io_qualifier, bit_index, bit_offset} <= {io, idx, off};
		bit_pointer <= ptr_reg;
		src_value <= val_reg;
		bit_circ <= circ_on;
		@(posedge clk);
		bit_req <= 1'b0;
		// Stale operands must not be mistaken for held ones
		bit_pointer <= ~ptr_reg;
		src_value <= ~val_reg;
		{ok, rj} = 2'b00;
		for (n = 0; n < 8 && !(ok || rj); n++) begin
			#1;
			{ok, rj} = {bit_done, bit_reject};
			if (ok !== 1'b1 && rj !== 1'b1) @(posedge clk);
		end
		// Write back only what the unit accepted
		if (ok === 1'b1) begin
			val_reg = bit_result;
			ptr_reg = bit_pointer_next;
		end
	endtask : issue
endmodule : mrb_core_model
